// ---- logic/aus_pkg.sv ----
package aus_pkg;
  // Operation
  // - Host waits 600 us after power-up
  // - Frames are 8 data, no parity, one stop
  // - Falling result-ready pin marks new result
  // - Sync byte 55h precedes every command
  // - Reset command, then host waits receive delay
  // - Register write: sync, opcode with address, data
  // - Register read 2xh returns addressed register
  // - Start command begins or restarts conversions
  // - Read-data command returns result in two bytes
  // - Sleep command stops conversions, powers down
  // - Selector 1110 shorts inputs to mid-supply
  // - Bypassed amplifier limits gain to 1, 2, 4
  // - Shared pin resets as input, not driving
  // - Host averages shorted readings, subtracts offset
  // - Device takes bit rate from sync byte
  // - Source select: 0 level bit, 1 ready

  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int POR_US = 600;
  localparam int POR_CYC = POR_US * CLK_MHZ;
  localparam int RST_RX_US = 100;
  localparam logic [15:0] RST_RX_CYC = 16'(RST_RX_US * CLK_MHZ);
  localparam int BAUD_RATE = 115_200;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam logic [15:0] BAUD_LAST = 16'(BAUD_DIV - 1);
  localparam logic [15:0] BAUD_HALF = 16'(BAUD_DIV + BAUD_DIV / 2 - 1);
  localparam int CONV_CYC = 2000;
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);
  localparam logic [15:0] RDY_HI_CNT = 16'(CONV_CYC / 2);

  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_RDATA = 8'h10;
  localparam logic [3:0] CMD_REG_WRITE = 4'h4;
  localparam logic [3:0] CMD_REG_READ = 4'h2;

  localparam int NUM_REGS = 5;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int SEL_LSB = 4;
  localparam int GAIN_LSB = 1;
  localparam int BYP_BIT = 0;
  localparam int CONT_BIT = 3;
  localparam int DIR2_BIT = 6;
  localparam int SRC_SEL_BIT = 3;
  localparam int DAT2_BIT = 2;
  localparam logic [3:0] SEL_SHORT = 4'he;
  localparam logic [2:0] GAIN_MAX_BYP = 3'h2;

  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RESULT = 8'h08;
  localparam logic [7:0] A_IRQ = 8'h0c;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_OFFS = 8'h14;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_DATA_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READY = 1;
  localparam logic [2:0] CAL_N = 3'h4;
  localparam int CAL_SHIFT = 2;

  typedef enum logic [2:0] {
    OP_RESET, OP_WRITE, OP_READ, OP_START, OP_RDATA, OP_SLEEP, OP_CAL
  } aus_op_t;
  typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_BITS, RX_STOP} aus_rx_t;

  // Start bit low, LSB first, stop bit high
  function automatic logic [9:0] aus_frame(input logic [7:0] d);
    return {1'b1, d, 1'b0};
  endfunction
endpackage

// ---- logic/aus_link_if.sv ----
interface aus_link_if;
  logic h2d;
  logic d2h;
  logic pin_out;
  logic pin_oe;
  logic pin_lvl;

  // Pull-up keeps the shared pin high while nobody drives it
  assign pin_lvl = pin_oe ? pin_out : 1'b1;

  modport dev(input h2d, input pin_lvl, output d2h, output pin_out,
    output pin_oe);
  modport host(output h2d, input d2h, input pin_lvl);
endinterface

// ---- logic/aus_dev.sv ----
module aus_dev import aus_pkg::*; (
  input wire logic core_clk_in, // 25 MHz clock
  input wire logic rst_in, // Sync reset, active high
  aus_link_if.dev link, // Serial link and shared pin
  input wire logic [15:0] sample_in, // Raw converter code
  output logic conv_active_out, // Converting
  output logic sleep_out, // Powered down
  output logic [3:0] selector_out, // Input selector field
  output logic short_out, // Inputs shorted to mid-supply
  output logic [2:0] gain_out, // Gain code in effect
  output logic [15:0] result_out // Last result
);
  typedef enum logic [1:0] {P_SYNC, P_CMD, P_WDATA} aus_ph_t;
  typedef struct packed {
    logic [2:0] rx_sy;
    logic [1:0] pin_sy;
    aus_rx_t rx_st;
    logic [15:0] rx_cnt;
    logic [15:0] bit_len;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    aus_ph_t ph;
    logic [2:0] wr_addr;
    logic [15:0] rst_cnt;
    logic [NUM_REGS-1:0][7:0] cfg;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [15:0] tx_cnt;
    logic tx_more;
    logic [7:0] tx_next;
    logic conv_on;
    logic sleeping;
    logic [15:0] conv_cnt;
    logic [15:0] result;
    logic rdy_n;
    logic tx_line;
    logic pin_out;
    logic pin_oe;
    logic [2:0] gain_eff;
    logic shorted;
  } aus_dev_st_t;

  aus_dev_st_t st_reg;
  aus_dev_st_t st_next;

  always_comb begin
    logic rx_done;
    logic fall;
    logic rise;
    logic [7:0] b;
    logic [2:0] g;
    rx_done = 1'b0;
    g = 3'h0;
    st_next = st_reg;
    // Bit [0] is the metastable stage; only bit [1] looks at it
    st_next.rx_sy = {st_reg.rx_sy[1:0], link.h2d};
    st_next.pin_sy = {st_reg.pin_sy[0], link.pin_lvl};
    fall = st_reg.rx_sy[2] & ~st_reg.rx_sy[1];
    rise = ~st_reg.rx_sy[2] & st_reg.rx_sy[1];
    b = st_reg.rx_sh;

    unique case (st_reg.rx_st)
      RX_IDLE: begin
        // Nothing heard until the post-reset delay has run out
        if (fall && st_reg.rst_cnt == 16'h0000) begin
          if (st_reg.ph == P_SYNC) begin
            st_next.rx_st = RX_MEAS;
            st_next.rx_cnt = 16'h0001;
          end else begin
            st_next.rx_st = RX_BITS;
            st_next.rx_bit = 3'h0;
            st_next.rx_cnt = st_reg.bit_len + {1'b0, st_reg.bit_len[15:1]}
              - 16'h0001;
          end
        end
      end
      RX_MEAS: begin
        // Start bit of 55h is one bit time: that is the bit rate
        if (rise) begin
          st_next.bit_len = st_reg.rx_cnt;
          st_next.rx_cnt = {1'b0, st_reg.rx_cnt[15:1]};
          st_next.rx_bit = 3'h0;
          st_next.rx_st = RX_BITS;
        end else if (st_reg.rx_cnt == 16'hffff) begin
          st_next.rx_st = RX_IDLE;
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
        end
      end
      RX_BITS: begin
        if (st_reg.rx_cnt == 16'h0000) begin
          st_next.rx_sh = {st_reg.rx_sy[1], st_reg.rx_sh[7:1]};
          st_next.rx_cnt = st_reg.bit_len - 16'h0001;
          st_next.rx_bit = st_reg.rx_bit + 3'h1;
          if (st_reg.rx_bit == 3'h7) begin
            st_next.rx_st = RX_STOP;
          end
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end
      end
      RX_STOP: begin
        if (st_reg.rx_cnt == 16'h0000) begin
          st_next.rx_st = RX_IDLE;
          rx_done = st_reg.rx_sy[1];
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end
      end
    endcase

    if (st_reg.rst_cnt != 16'h0000) begin
      st_next.rst_cnt = st_reg.rst_cnt - 16'h0001;
    end

    if (st_reg.conv_on) begin
      if (st_reg.conv_cnt == CONV_LAST) begin
        st_next.conv_cnt = 16'h0000;
        st_next.result = st_reg.shorted ? 16'h0000 : sample_in;
        st_next.rdy_n = 1'b0;
        if (!st_reg.cfg[1][CONT_BIT]) begin
          st_next.conv_on = 1'b0;
        end
      end else begin
        st_next.conv_cnt = st_reg.conv_cnt + 16'h0001;
        // Return high mid-period so each result gives a new fall
        if (st_reg.conv_cnt == RDY_HI_CNT) begin
          st_next.rdy_n = 1'b1;
        end
      end
    end

    if (st_reg.tx_busy) begin
      if (st_reg.tx_cnt == 16'h0000) begin
        st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
        st_next.tx_cnt = st_reg.bit_len - 16'h0001;
        st_next.tx_bits = st_reg.tx_bits - 4'h1;
        if (st_reg.tx_bits == 4'h1) begin
          if (st_reg.tx_more) begin
            st_next.tx_sh = aus_frame(st_reg.tx_next);
            st_next.tx_bits = 4'ha;
            st_next.tx_more = 1'b0;
          end else begin
            st_next.tx_busy = 1'b0;
          end
        end
      end else begin
        st_next.tx_cnt = st_reg.tx_cnt - 16'h0001;
      end
    end

    if (rx_done) begin
      unique case (st_reg.ph)
        P_SYNC: begin
          if (b == SYNC_BYTE) begin
            st_next.ph = P_CMD;
          end
        end
        P_CMD: begin
          st_next.ph = P_SYNC;
          if (b == CMD_RESET) begin
            st_next.cfg = {NUM_REGS{CFG_RST}};
            st_next.conv_on = 1'b0;
            st_next.sleeping = 1'b0;
            st_next.rdy_n = 1'b1;
            st_next.rst_cnt = RST_RX_CYC;
          end else if (b == CMD_START) begin
            st_next.conv_on = 1'b1;
            st_next.sleeping = 1'b0;
            st_next.conv_cnt = 16'h0000;
          end else if (b == CMD_SLEEP) begin
            st_next.conv_on = 1'b0;
            st_next.sleeping = 1'b1;
          end else if (b == CMD_RDATA && !st_reg.tx_busy) begin
            st_next.tx_busy = 1'b1;
            st_next.tx_sh = aus_frame(st_reg.result[15:8]);
            st_next.tx_bits = 4'ha;
            st_next.tx_cnt = st_reg.bit_len - 16'h0001;
            st_next.tx_next = st_reg.result[7:0];
            st_next.tx_more = 1'b1;
            st_next.rdy_n = 1'b1;
          end else if (b[7:4] == CMD_REG_WRITE && !b[0]) begin
            st_next.wr_addr = b[3:1];
            st_next.ph = P_WDATA;
          end else if (b[7:4] == CMD_REG_READ && !st_reg.tx_busy) begin
            st_next.tx_busy = 1'b1;
            st_next.tx_sh = aus_frame(
              (b[3:1] < 3'(NUM_REGS)) ? st_reg.cfg[b[3:1]] : 8'h00);
            st_next.tx_bits = 4'ha;
            st_next.tx_cnt = st_reg.bit_len - 16'h0001;
            st_next.tx_more = 1'b0;
          end
        end
        P_WDATA: begin
          st_next.ph = P_SYNC;
          if (st_reg.wr_addr < 3'(NUM_REGS)) begin
            st_next.cfg[st_reg.wr_addr] = b;
          end
        end
        default: st_next.ph = P_SYNC;
      endcase
    end

    // Level bit mirrors the pin while it is an input
    if (!st_next.cfg[4][DIR2_BIT]) begin
      st_next.cfg[4][DAT2_BIT] = st_reg.pin_sy[1];
    end
    st_next.pin_oe = st_next.cfg[4][DIR2_BIT];
    st_next.pin_out = st_next.cfg[4][SRC_SEL_BIT] ? st_next.rdy_n
      : st_next.cfg[4][DAT2_BIT];
    g = st_next.cfg[0][GAIN_LSB +: 3];
    st_next.gain_eff = (st_next.cfg[0][BYP_BIT] && g > GAIN_MAX_BYP)
      ? GAIN_MAX_BYP : g;
    st_next.shorted = st_next.cfg[0][SEL_LSB +: 4] == SEL_SHORT;
    st_next.tx_line = st_next.tx_busy ? st_next.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.rx_sy <= 3'h7;
      st_reg.bit_len <= 16'(BAUD_DIV);
      st_reg.rdy_n <= 1'b1;
      st_reg.tx_line <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.d2h = st_reg.tx_line;
  assign link.pin_out = st_reg.pin_out;
  assign link.pin_oe = st_reg.pin_oe;
  assign conv_active_out = st_reg.conv_on;
  assign sleep_out = st_reg.sleeping;
  assign selector_out = st_reg.cfg[0][SEL_LSB +: 4];
  assign short_out = st_reg.shorted;
  assign gain_out = st_reg.gain_eff;
  assign result_out = st_reg.result;
endmodule

// ---- logic/aus_host.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
module aus_host import aus_pkg::*; #(
  parameter int POR_WAIT_CYC = POR_CYC // Power-up wait in cycles
) (
  input wire logic core_clk_in, // 25 MHz clock
  input wire logic rst_in, // Sync reset, active high
  aus_link_if.host link, // Serial link and shared pin
  input wire logic [7:0] axi_awaddr_in, // AXI write address
  input wire logic axi_awvalid_in, // AXI write address valid
  output logic axi_awready_out, // AXI write address ready
  input wire logic [31:0] axi_wdata_in, // AXI write data
  input wire logic [3:0] axi_wstrb_in, // AXI byte strobes
  input wire logic axi_wvalid_in, // AXI write data valid
  output logic axi_wready_out, // AXI write data ready
  output logic [1:0] axi_bresp_out, // AXI write response
  output logic axi_bvalid_out, // AXI write response valid
  input wire logic axi_bready_in, // AXI write response ready
  input wire logic [7:0] axi_araddr_in, // AXI read address
  input wire logic axi_arvalid_in, // AXI read address valid
  output logic axi_arready_out, // AXI read address ready
  output logic [31:0] axi_rdata_out, // AXI read data
  output logic [1:0] axi_rresp_out, // AXI read response
  output logic axi_rvalid_out, // AXI read data valid
  input wire logic axi_rready_in, // AXI read data ready
  output logic irq_out // Level interrupt
);
  typedef enum logic [2:0] {H_POR, H_IDLE, H_SEND, H_RECV, H_WAIT, H_CALW}
    aus_hst_t;
  typedef struct packed {
    logic [2:0] rx_sy;
    logic [2:0] rdy_sy;
    aus_rx_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [15:0] tx_cnt;
    logic [23:0] q;
    logic [1:0] qn;
    aus_hst_t hst;
    aus_op_t op;
    logic [15:0] wait_cnt;
    logic [1:0] nrx;
    logic [15:0] acc;
    logic [2:0] cal_left;
    logic [17:0] cal_sum;
    logic [15:0] offset;
    logic [15:0] result;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic awready;
    logic wready;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic tx_line;
  } aus_host_st_t;

  aus_host_st_t st_reg;
  aus_host_st_t st_next;

  always_comb begin
    logic rx_done;
    logic rdy_fall;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [15:0] word;
    rx_done = 1'b0;
    ev = 2'h0;
    clr = 2'h0;
    word = {st_reg.acc[7:0], st_reg.rx_sh};
    st_next = st_reg;
    st_next.rx_sy = {st_reg.rx_sy[1:0], link.d2h};
    st_next.rdy_sy = {st_reg.rdy_sy[1:0], link.pin_lvl};
    rdy_fall = st_reg.rdy_sy[2] & ~st_reg.rdy_sy[1];
    ev[IRQ_READY] = rdy_fall;

    unique case (st_reg.rx_st)
      RX_IDLE: begin
        if (st_reg.rx_sy[2] & ~st_reg.rx_sy[1]) begin
          st_next.rx_st = RX_BITS;
          st_next.rx_cnt = BAUD_HALF;
          st_next.rx_bit = 3'h0;
        end
      end
      RX_BITS: begin
        if (st_reg.rx_cnt == 16'h0000) begin
          st_next.rx_sh = {st_reg.rx_sy[1], st_reg.rx_sh[7:1]};
          st_next.rx_cnt = BAUD_LAST;
          st_next.rx_bit = st_reg.rx_bit + 3'h1;
          if (st_reg.rx_bit == 3'h7) begin
            st_next.rx_st = RX_STOP;
          end
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end
      end
      RX_STOP: begin
        if (st_reg.rx_cnt == 16'h0000) begin
          st_next.rx_st = RX_IDLE;
          rx_done = st_reg.rx_sy[1];
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end
      end
      default: st_next.rx_st = RX_IDLE;
    endcase

    // Host alone sets the bit rate through its own divider
    if (st_reg.tx_busy) begin
      if (st_reg.tx_cnt == 16'h0000) begin
        st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
        st_next.tx_cnt = BAUD_LAST;
        st_next.tx_bits = st_reg.tx_bits - 4'h1;
        st_next.tx_busy = st_reg.tx_bits != 4'h1;
      end else begin
        st_next.tx_cnt = st_reg.tx_cnt - 16'h0001;
      end
    end

    unique case (st_reg.hst)
      H_POR: begin
        if (st_reg.wait_cnt == 16'(POR_WAIT_CYC - 1)) begin
          st_next.hst = H_IDLE;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt + 16'h0001;
        end
      end
      H_IDLE: ;
      H_SEND: begin
        if (!st_reg.tx_busy && st_reg.qn != 2'h0) begin
          st_next.tx_busy = 1'b1;
          st_next.tx_sh = aus_frame(st_reg.q[23:16]);
          st_next.tx_bits = 4'ha;
          st_next.tx_cnt = BAUD_LAST;
          st_next.q = {st_reg.q[15:0], 8'h00};
          st_next.qn = st_reg.qn - 2'h1;
        end else if (!st_reg.tx_busy) begin
          if (st_reg.nrx != 2'h0) begin
            st_next.hst = H_RECV;
          end else if (st_reg.op == OP_RESET) begin
            st_next.hst = H_WAIT;
            st_next.wait_cnt = RST_RX_CYC;
          end else begin
            st_next.hst = H_IDLE;
            ev[IRQ_DONE] = 1'b1;
          end
        end
      end
      H_RECV: begin
        if (rx_done) begin
          st_next.acc = word;
          st_next.nrx = st_reg.nrx - 2'h1;
          if (st_reg.nrx == 2'h1) begin
            st_next.hst = H_IDLE;
            ev[IRQ_DONE] = 1'b1;
            if (st_reg.op == OP_READ) begin
              st_next.result = {8'h00, st_reg.rx_sh};
            end else if (st_reg.op == OP_RDATA) begin
              st_next.result = word - st_reg.offset;
            end else begin
              // Signed sum keeps a negative offset negative
              st_next.cal_sum = st_reg.cal_sum + {{2{word[15]}}, word};
              st_next.cal_left = st_reg.cal_left - 3'h1;
              if (st_reg.cal_left == 3'h1) begin
                st_next.offset = 16'(st_next.cal_sum >> CAL_SHIFT);
              end else begin
                st_next.hst = H_CALW;
                ev[IRQ_DONE] = 1'b0;
              end
            end
          end
        end
      end
      H_WAIT: begin
        if (st_reg.wait_cnt == 16'h0000) begin
          st_next.hst = H_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - 16'h0001;
        end
      end
      H_CALW: begin
        if (rdy_fall) begin
          st_next.q = {SYNC_BYTE, CMD_RDATA, 8'h00};
          st_next.qn = 2'h2;
          st_next.nrx = 2'h2;
          st_next.hst = H_SEND;
        end
      end
      default: st_next.hst = H_IDLE;
    endcase

    if (axi_awvalid_in && st_reg.awready) begin
      st_next.awready = 1'b0;
      st_next.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && st_reg.wready) begin
      st_next.wready = 1'b0;
      st_next.wdata = axi_wdata_in;
      st_next.wstrb = axi_wstrb_in;
    end
    if (!st_reg.awready && !st_reg.wready && !st_reg.bvalid) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'h0;
      if (st_reg.awaddr == A_MASK && st_reg.wstrb[0]) begin
        st_next.irq_mask = st_reg.wdata[1:0];
      end else if (st_reg.awaddr == A_CMD && st_reg.wstrb[0]) begin
        // Commands while busy are dropped; software polls busy first
        if (st_reg.hst == H_IDLE) begin
          st_next.op = aus_op_t'(st_reg.wdata[2:0]);
          st_next.hst = H_SEND;
          st_next.nrx = 2'h0;
          st_next.qn = 2'h2;
          st_next.q = {SYNC_BYTE, 16'h0000};
          unique case (aus_op_t'(st_reg.wdata[2:0]))
            OP_RESET: st_next.q[15:8] = CMD_RESET;
            OP_WRITE: begin
              st_next.q[15:8] = {CMD_REG_WRITE,
                st_reg.wdata[CMD_ADDR_LSB +: 3], 1'b0};
              st_next.q[7:0] = st_reg.wdata[CMD_DATA_LSB +: 8];
              st_next.qn = 2'h3;
            end
            OP_READ: begin
              st_next.q[15:8] = {CMD_REG_READ,
                st_reg.wdata[CMD_ADDR_LSB +: 3], 1'b0};
              st_next.nrx = 2'h1;
            end
            OP_START: st_next.q[15:8] = CMD_START;
            OP_RDATA: begin
              st_next.q[15:8] = CMD_RDATA;
              st_next.nrx = 2'h2;
            end
            OP_SLEEP: st_next.q[15:8] = CMD_SLEEP;
            OP_CAL: begin
              st_next.hst = H_CALW;
              st_next.cal_left = CAL_N;
              st_next.cal_sum = 18'h00000;
            end
            default: st_next.hst = H_IDLE;
          endcase
        end
      end else if (st_reg.awaddr != A_CMD && st_reg.awaddr != A_MASK) begin
        st_next.bresp = 2'h2;
      end
    end
    if (st_reg.bvalid && axi_bready_in) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    if (axi_arvalid_in && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'h0;
      st_next.rdata = 32'h0;
      unique case (axi_araddr_in)
        A_STAT: st_next.rdata[1:0] = {st_reg.rdy_sy[1],
          st_reg.hst != H_IDLE};
        A_RESULT: st_next.rdata[15:0] = st_reg.result;
        A_IRQ: begin
          st_next.rdata[1:0] = st_reg.irq_stat;
          clr = 2'h3;
        end
        A_MASK: st_next.rdata[1:0] = st_reg.irq_mask;
        A_OFFS: st_next.rdata[15:0] = st_reg.offset;
        A_CMD: ;
        default: st_next.rresp = 2'h2;
      endcase
    end
    if (st_reg.rvalid && axi_rready_in) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // An event in the clearing cycle survives the read
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
    st_next.tx_line = st_next.tx_busy ? st_next.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.rx_sy <= 3'h7;
      st_reg.rdy_sy <= 3'h7;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.tx_line <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.h2d = st_reg.tx_line;
  assign axi_awready_out = st_reg.awready;
  assign axi_wready_out = st_reg.wready;
  assign axi_bresp_out = st_reg.bresp;
  assign axi_bvalid_out = st_reg.bvalid;
  assign axi_arready_out = st_reg.arready;
  assign axi_rdata_out = st_reg.rdata;
  assign axi_rresp_out = st_reg.rresp;
  assign axi_rvalid_out = st_reg.rvalid;
  assign irq_out = st_reg.irq;
endmodule

// ---- tb/aus_asserts.sv ----
module aus_asserts (
  input wire logic core_clk_in, // Clock
  input wire logic rst_in, // Sync reset
  input wire logic h2d_in, // Host line
  input wire logic d2h_in, // Device line
  input wire logic pin_oe_in, // Pin drive
  input wire logic pin_lvl_in // Pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Half of a 217-cycle bit: any edge must hold past mid-bit
  a_tx_low_len: assert property ($fell(d2h_in) |-> ##108 !d2h_in)
    else $error("device low bit too short");
  a_tx_high_len: assert property ($rose(d2h_in) |-> ##108 d2h_in)
    else $error("device high bit too short");
  a_rx_low_len: assert property ($fell(h2d_in) |-> ##108 !h2d_in)
    else $error("host low bit too short");
  a_rx_high_len: assert property ($rose(h2d_in) |-> ##108 h2d_in)
    else $error("host high bit too short");
  a_rst_lines: assert property ($fell(rst_in) |-> h2d_in && d2h_in)
    else $error("lines not idle after reset");
  a_rst_pin_in: assert property ($fell(rst_in) |-> !pin_oe_in)
    else $error("pin driven after reset");
  a_quiet_boot: assert property ($fell(rst_in) |=> d2h_in [*8])
    else $error("device spoke unasked");
  a_rdy_low: assert property (
    $fell(pin_lvl_in) && pin_oe_in |=> !pin_lvl_in [*8])
    else $error("ready pulse too short");
  a_pin_hold: assert property ($rose(pin_oe_in) |=> pin_oe_in [*8])
    else $error("pin drive glitched");
endmodule

// ---- tb/testbench.sv ----
module testbench import aus_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, irq, conv, slp, shrt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp;
  logic [3:0] sel;
  logic [2:0] gain;
  logic [15:0] res;
  int bad_count, comparisons;
  aus_link_if lk();
  aus_dev u_aus_dev(.core_clk_in(clk), .rst_in(rst), .link(lk),
    .sample_in(16'h1234), .conv_active_out(conv), .sleep_out(slp),
    .selector_out(sel), .short_out(shrt), .gain_out(gain), .result_out(res));
  aus_host #(.POR_WAIT_CYC(50)) u_aus_host(.core_clk_in(clk), .rst_in(rst),
    .link(lk), .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(4'hf),
    .axi_wvalid_in(wvalid), .axi_wready_out(wready), .axi_bresp_out(bresp),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .irq_out(irq));
  aus_asserts u_aus_asserts(.core_clk_in(clk), .rst_in(rst),
    .h2d_in(lk.h2d), .d2h_in(lk.d2h), .pin_oe_in(lk.pin_oe),
    .pin_lvl_in(lk.pin_lvl));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Ready lines stay high: the bench never stalls a response
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
      input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    chk("rdata", e, rdata & m);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic idle();
    do rd(A_STAT, 0, 0, 2'h0); while (rv[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [2:0] op, ad, input logic [7:0] dt);
    wr(A_CMD, {16'h0, dt, 1'b0, ad, 1'b0, op}, 2'h0);
    idle();
  endtask
  initial begin
    #4_000_000;
    bad_count++;
    close_out();
  end
  initial begin
    {rst, bready, rready} = 3'h7;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pin_oe", 0, lk.pin_oe);
    rd(A_MASK, '1, 0, 2'h0);
    rd(8'h40, '1, 0, 2'h2);
    wr(8'h40, 0, 2'h2);
    idle();
    wr(A_MASK, 32'h1, 2'h0);
    cmd(OP_WRITE, 3'h0, 8'he0);
    chk("irq", 1, irq);
    rd(A_IRQ, 32'h1, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    wr(A_MASK, 0, 2'h0);
    chk("sel", 32'(SEL_SHORT), 32'(sel));
    chk("short", 1, shrt);
    cmd(OP_WRITE, 3'h0, 8'h0b);
    chk("gain", 32'(GAIN_MAX_BYP), 32'(gain));
    cmd(OP_READ, 3'h0, 8'h0);
    rd(A_RESULT, 32'hff, 32'h0b, 2'h0);
    $display("test config done");
    cmd(OP_WRITE, 3'h4, 8'h48);
    chk("pin_oe", 1, lk.pin_oe);
    cmd(OP_WRITE, 3'h1, 8'h08);
    cmd(OP_START, 3'h0, 8'h0);
    chk("conv", 1, conv);
    do rd(A_IRQ, 0, 0, 2'h0); while (rv[1] !== 1'b1);
    cmd(OP_RDATA, 3'h0, 8'h0);
    rd(A_RESULT, 32'hffff, 32'h1234, 2'h0);
    chk("result", 32'h1234, 32'(res));
    $display("test convert done");
    cmd(OP_SLEEP, 3'h0, 8'h0);
    chk("sleep", 1, slp);
    chk("conv", 0, conv);
    cmd(OP_RESET, 3'h0, 8'h0);
    chk("sel", 0, sel);
    chk("pin_oe", 0, lk.pin_oe);
    $display("test power done");
    close_out();
  end
endmodule
